// File: logic/serial_handshake_output_formatter.sv
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module serial_handshake_output_formatter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_accept,
	output logic [7:0] rx_out_data,
	input wire logic resp_valid,
	input wire logic [7:0] resp_data,
	input wire logic resp_last,
	output logic resp_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic [15:0] buf_level,
	output logic dtr
);
	localparam int unsigned LIST_LEN_I = fmt_pkg::LIST_LEN;
	// Parameters set by device-control commands.
	logic [13:0] turn_q;
	logic [6:0] trig_q, echo_q, term1_q, term2_q, init_q, enq_q;
	logic [13:0] icd_q;
	logic [6:0] list_q [LIST_LEN_I];
	logic [6:0] ack_q [LIST_LEN_I];
	logic [6:0] xon_q [LIST_LEN_I];
	logic [3:0] list_len_q, ack_len_q, xon_len_q;
	logic [15:0] block_q, bufsize_q, xoff_thr_q;
	logic xonxoff_q, hardwire_q;

	function automatic logic [13:0] clamp_ms(input logic [15:0] v);
		clamp_ms = (v > {2'b00, fmt_pkg::DELAY_MAX}) ? fmt_pkg::DELAY_MAX : v[13:0]; // R2
	endfunction

	wire logic [3:0] widx = reg_wdata[11:8];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			turn_q <= '0; // R1
			trig_q <= '0;
			echo_q <= '0;
			term1_q <= fmt_pkg::TERM_DEFAULT; // R1
			term2_q <= '0;
			init_q <= '0;
		end else if (reg_wr && reg_addr == fmt_pkg::A_CMD && reg_wdata[fmt_pkg::CMD_FMT_DEFAULT]) begin
			turn_q <= '0; // R1
			trig_q <= '0;
			echo_q <= '0;
			term1_q <= fmt_pkg::TERM_DEFAULT;
			term2_q <= '0;
			init_q <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				fmt_pkg::A_TURN: begin
					turn_q <= clamp_ms(reg_wdata); // R2
				end
				fmt_pkg::A_TRIG: begin
					trig_q <= (reg_wdata[6:0] == 7'h7f) ? 7'h00 : reg_wdata[6:0]; // R3
				end
				fmt_pkg::A_ECHO: begin
					echo_q <= (reg_wdata[6:0] == 7'h7f) ? 7'h00 : reg_wdata[6:0]; // R5
				end
				fmt_pkg::A_TERM: begin
					term1_q <= reg_wdata[6:0]; // R6
					term2_q <= reg_wdata[14:8];
				end
				fmt_pkg::A_INIT: begin
					init_q <= reg_wdata[6:0]; // R8
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			icd_q <= '0; // R12
			list_len_q <= '0;
			for (int i = 0; i < LIST_LEN_I; i++) begin
				list_q[i] <= '0;
			end
		end else if (reg_wr && reg_addr == fmt_pkg::A_CMD && reg_wdata[fmt_pkg::CMD_EXT_DEFAULT]) begin
			icd_q <= '0; // R12
			list_len_q <= '0;
		end else if (reg_wr && reg_addr == fmt_pkg::A_ICD) begin
			icd_q <= clamp_ms(reg_wdata); // R11
		end else if (reg_wr && reg_addr == fmt_pkg::A_LISTLEN) begin
			list_len_q <= (reg_wdata[3:0] > 4'd10) ? 4'd10 : reg_wdata[3:0]; // R13
		end else if (reg_wr && reg_addr == fmt_pkg::A_LIST && widx < 4'd10) begin
			list_q[widx] <= reg_wdata[6:0]; // R13
		end
	end

	// Handshake configuration: enquiry, acknowledge, Xon, block and buffer sizes.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enq_q <= '0;
			ack_len_q <= '0;
			xon_len_q <= '0;
			block_q <= fmt_pkg::BLOCK_DEFAULT;
			bufsize_q <= fmt_pkg::BUFSIZE_DEFAULT;
			xoff_thr_q <= fmt_pkg::XOFF_THR_DEFAULT; // R21
			xonxoff_q <= 1'b0;
			hardwire_q <= 1'b0;
			for (int i = 0; i < LIST_LEN_I; i++) begin
				ack_q[i] <= '0;
				xon_q[i] <= '0;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				fmt_pkg::A_ENQ: enq_q <= (reg_wdata[6:0] == 7'h7f) ? 7'h00 : reg_wdata[6:0];
				fmt_pkg::A_ACKLEN: ack_len_q <= (reg_wdata[3:0] > 4'd10) ? 4'd10 : reg_wdata[3:0];
				fmt_pkg::A_ACK: if (widx < 4'd10) ack_q[widx] <= reg_wdata[6:0];
				fmt_pkg::A_XONLEN: xon_len_q <= (reg_wdata[3:0] > 4'd10) ? 4'd10 : reg_wdata[3:0];
				fmt_pkg::A_XON: if (widx < 4'd10) xon_q[widx] <= reg_wdata[6:0];
				fmt_pkg::A_BLOCK: block_q <= reg_wdata;
				fmt_pkg::A_BUFSIZE: bufsize_q <= reg_wdata;
				fmt_pkg::A_XOFFTHR: xoff_thr_q <= reg_wdata;
				fmt_pkg::A_MODE: begin
					xonxoff_q <= reg_wdata[fmt_pkg::MODE_XONXOFF];
					hardwire_q <= reg_wdata[fmt_pkg::MODE_HARDWIRE]; // R19
				end
				fmt_pkg::A_CMD: if (reg_wdata[fmt_pkg::CMD_THR_DEFAULT]) xoff_thr_q <= fmt_pkg::XOFF_THR_DEFAULT;
				default: begin
				end
			endcase
		end
	end

	// Threshold is held as an offset, so a new buffer size moves the Xoff level with it.
	wire logic [15:0] xoff_level = bufsize_q - xoff_thr_q; // R21
	wire logic [15:0] xon_level = xoff_level - block_q; // R23
	wire logic [15:0] free_space = (buf_level >= bufsize_q) ? 16'h0000 : bufsize_q - buf_level;
	wire logic enq_on = (enq_q != 7'h00) && !xonxoff_q; // R16

	// Millisecond timebase.
	logic [16:0] div_q;
	logic tick_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else if (div_q == 17'(fmt_pkg::TICK_CYCLES - 1)) begin
			div_q <= '0;
			tick_q <= 1'b1; // R25
		end else begin
			div_q <= div_q + 17'd1;
			tick_q <= 1'b0;
		end
	end

	// Receive side: trigger, echo discard, enquiry.
	logic trig_seen_q, echo_hold_q, enq_pend_q, imm_pend_q;
	logic rx_accept_q;
	logic [7:0] rx_out_q;
	logic resp_done, enq_go, imm_go;
	fmt_pkg::tx_e st_q;
	wire logic rx_is = rx_valid && rx_data[7] == 1'b0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_seen_q <= 1'b0;
			echo_hold_q <= 1'b0;
			enq_pend_q <= 1'b0;
			imm_pend_q <= 1'b0;
			rx_accept_q <= 1'b0;
			rx_out_q <= '0;
		end else begin
			rx_accept_q <= 1'b0;
			rx_out_q <= rx_data;
			if (resp_done) begin
				trig_seen_q <= 1'b0;
				echo_hold_q <= (echo_q != 7'h00); // R5
			end
			if (enq_go) enq_pend_q <= 1'b0;
			if (imm_go) imm_pend_q <= 1'b0;
			if (rx_valid) begin
				if (echo_hold_q) begin
					if (rx_is && rx_data[6:0] == echo_q && !resp_done) echo_hold_q <= 1'b0; // R5
				end else if (enq_on && rx_is && rx_data[6:0] == enq_q) begin
					enq_pend_q <= 1'b1; // R15
					imm_pend_q <= (list_len_q != 4'd0) && (list_q[0] != 7'h00); // R14
				end else begin
					rx_accept_q <= 1'b1;
					if (trig_q != 7'h00 && rx_is && rx_data[6:0] == trig_q) trig_seen_q <= 1'b1; // R4
				end
			end
		end
	end

	// Flow control decisions.
	logic xoff_sent_q, dtr_q, xoff_go, xon_go;
	assign xoff_go = xonxoff_q && !xoff_sent_q && buf_level > xoff_level; // R20
	assign xon_go = xonxoff_q && xoff_sent_q && buf_level <= xon_level; // R22 R23
	assign enq_go = st_q == fmt_pkg::TX_IDLE && !xoff_go && !xon_go && enq_pend_q && !imm_pend_q
		&& free_space >= block_q; // R15
	assign imm_go = st_q == fmt_pkg::TX_IDLE && !xoff_go && !xon_go && imm_pend_q; // R14
	wire logic resp_go = resp_valid && (trig_q == 7'h00 || trig_seen_q); // R4

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dtr_q <= 1'b1;
		end else if (!hardwire_q) begin
			dtr_q <= 1'b1; // R19
		end else if (free_space < block_q) begin
			dtr_q <= 1'b0; // R24
		end else if (free_space > block_q) begin
			dtr_q <= 1'b1; // R24
		end
	end

	// Transmit sequencer.
	fmt_pkg::src_e src_q;
	logic [13:0] cnt_q;
	logic [1:0] phase_q;
	logic [3:0] idx_q;
	logic flow_off_q, tx_valid_q, resp_ready_q, last_q;
	logic [7:0] tx_data_q;
	logic [6:0] ch;
	logic ch_ok, last_pick;

	// Phase 0 initiator, 1 body, 2 first terminator, 3 second terminator.
	always_comb begin
		ch = 7'h00;
		ch_ok = 1'b0;
		last_pick = 1'b0;
		case (src_q)
			fmt_pkg::SRC_RESP: begin
				case (phase_q)
					2'd0: begin
						ch = init_q;
						ch_ok = init_q != 7'h00; // R8
					end
					2'd1: begin
						ch = resp_data[6:0];
						ch_ok = resp_valid;
					end
					2'd2: begin
						ch = term1_q;
						ch_ok = term1_q != 7'h00; // R6 R9
						last_pick = !ch_ok || term2_q == 7'h00;
					end
					default: begin
						ch = term2_q;
						ch_ok = term1_q != 7'h00 && term2_q != 7'h00; // R6
						last_pick = 1'b1;
					end
				endcase
			end
			fmt_pkg::SRC_IMM: begin
				ch = list_q[idx_q];
				ch_ok = idx_q < list_len_q && list_q[idx_q] != 7'h00;
				last_pick = !ch_ok || idx_q + 4'd1 >= list_len_q;
			end
			fmt_pkg::SRC_ACK: begin
				ch = ack_q[idx_q];
				ch_ok = idx_q < ack_len_q && ack_q[idx_q] != 7'h00;
				last_pick = !ch_ok || idx_q + 4'd1 >= ack_len_q;
			end
			default: begin
				ch = flow_off_q ? list_q[idx_q] : xon_q[idx_q];
				ch_ok = idx_q < (flow_off_q ? list_len_q : xon_len_q) && ch != 7'h00;
				last_pick = !ch_ok || idx_q + 4'd1 >= (flow_off_q ? list_len_q : xon_len_q);
			end
		endcase
	end

	assign resp_done = src_q == fmt_pkg::SRC_RESP && phase_q[1] && ((st_q == fmt_pkg::TX_WAIT
		&& tx_ready && last_pick) || (st_q == fmt_pkg::TX_SEND && !ch_ok));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= fmt_pkg::TX_IDLE;
			last_q <= 1'b0;
			src_q <= fmt_pkg::SRC_RESP;
			cnt_q <= '0;
			phase_q <= '0;
			idx_q <= '0;
			flow_off_q <= 1'b0;
			xoff_sent_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_data_q <= '0;
			resp_ready_q <= 1'b0;
		end else begin
			resp_ready_q <= 1'b0;
			case (st_q)
				fmt_pkg::TX_IDLE: begin
					idx_q <= '0;
					phase_q <= '0;
					if (xoff_go || xon_go) begin
						src_q <= fmt_pkg::SRC_FLOW;
						flow_off_q <= xoff_go;
						xoff_sent_q <= xoff_go;
						cnt_q <= icd_q; // R11
						st_q <= fmt_pkg::TX_GAP;
					end else if (imm_go) begin
						src_q <= fmt_pkg::SRC_IMM;
						cnt_q <= icd_q;
						st_q <= fmt_pkg::TX_GAP;
					end else if (enq_go) begin
						src_q <= fmt_pkg::SRC_ACK;
						cnt_q <= turn_q;
						st_q <= fmt_pkg::TX_TURN;
					end else if (resp_go) begin
						src_q <= fmt_pkg::SRC_RESP;
						cnt_q <= turn_q; // R10
						st_q <= fmt_pkg::TX_TURN;
					end
				end
				fmt_pkg::TX_TURN, fmt_pkg::TX_GAP: begin
					if (cnt_q == 14'd0) begin
						if (st_q == fmt_pkg::TX_TURN) begin
							cnt_q <= icd_q; // R11
							st_q <= fmt_pkg::TX_GAP;
						end else begin
							st_q <= fmt_pkg::TX_SEND;
						end
					end else if (tick_q) begin
						cnt_q <= cnt_q - 14'd1; // R25
					end
				end
				fmt_pkg::TX_SEND: begin
					if (src_q == fmt_pkg::SRC_RESP && phase_q == 2'd0 && !ch_ok) begin
						phase_q <= 2'd1;
					end else if (ch_ok) begin
						tx_valid_q <= 1'b1;
						tx_data_q <= {1'b0, ch};
						last_q <= resp_last;
						if (src_q == fmt_pkg::SRC_RESP && phase_q == 2'd1) resp_ready_q <= 1'b1;
						st_q <= fmt_pkg::TX_WAIT;
					end else if (src_q != fmt_pkg::SRC_RESP || phase_q[1]) begin
						st_q <= fmt_pkg::TX_IDLE;
					end
				end
				default: begin
					if (tx_ready) begin
						tx_valid_q <= 1'b0;
						cnt_q <= icd_q; // R11
						st_q <= fmt_pkg::TX_GAP;
						if (src_q == fmt_pkg::SRC_RESP) begin
							if (phase_q == 2'd1 && last_q) phase_q <= 2'd2; // R9
							else if (phase_q != 2'd1) phase_q <= phase_q + 2'd1;
							if (phase_q[1] && last_pick) st_q <= fmt_pkg::TX_IDLE;
						end else begin
							idx_q <= idx_q + 4'd1;
							if (last_pick) st_q <= fmt_pkg::TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Register read port.
	logic [15:0] rd_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				fmt_pkg::A_TURN: rd_q <= {2'b00, turn_q};
				fmt_pkg::A_TRIG: rd_q <= {9'h000, trig_q};
				fmt_pkg::A_ECHO: rd_q <= {9'h000, echo_q};
				fmt_pkg::A_TERM: rd_q <= {1'b0, term2_q, 1'b0, term1_q};
				fmt_pkg::A_INIT: rd_q <= {9'h000, init_q};
				fmt_pkg::A_ICD: rd_q <= {2'b00, icd_q};
				fmt_pkg::A_LISTLEN: rd_q <= {12'h000, list_len_q};
				fmt_pkg::A_ENQ: rd_q <= {9'h000, enq_q};
				fmt_pkg::A_ACKLEN: rd_q <= {12'h000, ack_len_q};
				fmt_pkg::A_XONLEN: rd_q <= {12'h000, xon_len_q};
				fmt_pkg::A_BLOCK: rd_q <= block_q;
				fmt_pkg::A_BUFSIZE: rd_q <= bufsize_q;
				fmt_pkg::A_XOFFTHR: rd_q <= xoff_thr_q;
				fmt_pkg::A_MODE: rd_q <= {14'h0000, hardwire_q, xonxoff_q};
				fmt_pkg::A_STATUS: rd_q <= {9'h000, st_q, echo_hold_q, trig_seen_q, xoff_sent_q, dtr_q};
				default: rd_q <= '0;
			endcase
		end else begin
			rd_q <= '0;
		end
	end

	assign reg_rdata = rd_q;
	assign rx_accept = rx_accept_q;
	assign rx_out_data = rx_out_q;
	assign resp_ready = resp_ready_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign dtr = dtr_q;
endmodule // serial_handshake_output_formatter
`default_nettype wire

// File: common/fmt_pkg.sv
// What this block does
// R1: Reset or bare format command restores defaults.
// R2: Turnaround delay 0..9999 ms, omitted is zero.
// R3: One trigger character, zero means none.
// R4: Response waits for trigger character arrival.
// R5: Echo terminate discards input until seen.
// R6: Terminator two codes, zero ends early.
// R7: Host gives two terminator codes with initiator.
// R8: Nonzero initiator sent before each response string.
// R9: Terminator appended after every response.
// R10: Turnaround delay before first response character.
// R11: Intercharacter delay before every sent character.
// R12: Reset or bare extended command clears delay, list.
// R13: Ten-code list: Xoff trigger or immediate response.
// R14: Immediate response sent right after enquiry.
// R15: Acknowledge only when a block fits.
// R16: Zero enquiry disables enquire/acknowledge.
// R17: Host waits for acknowledge before each block.
// R18: Host never exceeds the block size.
// R19: Hardwire disabled holds terminal-ready asserted.
// R20: Xoff sent when level exceeds size minus threshold.
// R21: Threshold defaults 80 below buffer size.
// R22: Xon sent when space returns.
// R23: Xon level one block below Xoff level.
// R24: Terminal-ready follows free space against block size.
// R25: Millisecond tick times all delays.
package fmt_pkg;
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;
	localparam logic [13:0] DELAY_MAX = 14'd9999;
	localparam logic [6:0] TERM_DEFAULT = 7'h0d;
	localparam logic [15:0] BLOCK_DEFAULT = 16'h0050;
	localparam logic [15:0] BUFSIZE_DEFAULT = 16'h0400;
	localparam logic [15:0] XOFF_THR_DEFAULT = 16'h0050;
	localparam int unsigned LIST_LEN = 10;
	localparam int unsigned ACK_LEN = 10;
	// Register offsets.
	localparam logic [4:0] A_TURN = 5'h00;
	localparam logic [4:0] A_TRIG = 5'h01;
	localparam logic [4:0] A_ECHO = 5'h02;
	localparam logic [4:0] A_TERM = 5'h03;
	localparam logic [4:0] A_INIT = 5'h04;
	localparam logic [4:0] A_ICD = 5'h05;
	localparam logic [4:0] A_LISTLEN = 5'h06;
	localparam logic [4:0] A_LIST = 5'h07;
	localparam logic [4:0] A_ENQ = 5'h08;
	localparam logic [4:0] A_ACKLEN = 5'h09;
	localparam logic [4:0] A_ACK = 5'h0a;
	localparam logic [4:0] A_BLOCK = 5'h0b;
	localparam logic [4:0] A_BUFSIZE = 5'h0c;
	localparam logic [4:0] A_XOFFTHR = 5'h0d;
	localparam logic [4:0] A_MODE = 5'h0e;
	localparam logic [4:0] A_CMD = 5'h0f;
	localparam logic [4:0] A_STATUS = 5'h10;
	localparam logic [4:0] A_XONLEN = 5'h11;
	localparam logic [4:0] A_XON = 5'h12;
	// Command register bits.
	localparam int unsigned CMD_FMT_DEFAULT = 0;
	localparam int unsigned CMD_EXT_DEFAULT = 1;
	localparam int unsigned CMD_THR_DEFAULT = 2;
	// Mode register bits.
	localparam int unsigned MODE_XONXOFF = 0;
	localparam int unsigned MODE_HARDWIRE = 1;
	typedef enum logic [1:0] {SRC_RESP, SRC_IMM, SRC_ACK, SRC_FLOW} src_e;
	typedef enum logic [2:0] {
		TX_IDLE, TX_TURN, TX_GAP, TX_SEND, TX_WAIT
	} tx_e;
endpackage

// File: tb/fmt_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fmt_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_accept,
	input wire logic [7:0] rx_out_data,
	input wire logic resp_valid,
	input wire logic [7:0] resp_data,
	input wire logic resp_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic [15:0] buf_level,
	input wire logic dtr
);
	// Only valid for the default buffer and block sizes, which the hardwire runs keep.
	localparam logic [15:0] DTR_EDGE = fmt_pkg::BUFSIZE_DEFAULT - fmt_pkg::BLOCK_DEFAULT;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_held;
		tx_valid && !tx_ready;
	endsequence
	sequence s_take;
		resp_ready && resp_valid;
	endsequence
	property p_accept_src;
		rx_accept |-> $past(rx_valid) && rx_out_data == $past(rx_data);
	endproperty
	a_accept_src: assert property (p_accept_src) else $error("accept without byte");
	property p_tx_hold;
		s_held |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("character dropped");
	property p_take_data;
		s_take |-> $rose(tx_valid) && tx_data == resp_data;
	endproperty
	a_take_data: assert property (p_take_data) else $error("body byte lost");
	property p_ready_valid;
		resp_ready |-> resp_valid;
	endproperty
	a_ready_valid: assert property (p_ready_valid) else $error("take without source");
	property p_ready_once;
		resp_ready |=> !resp_ready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("double take");
	property p_dtr_fall;
		$fell(dtr) |-> $past(buf_level) > DTR_EDGE;
	endproperty
	a_dtr_fall: assert property (p_dtr_fall) else $error("ready dropped early");
	property p_dtr_low;
		!dtr |-> $past(buf_level) >= DTR_EDGE;
	endproperty
	a_dtr_low: assert property (p_dtr_low) else $error("ready held low");
	property p_reset_quiet;
		$rose(rst_n) |-> dtr && !tx_valid && !rx_accept && !resp_ready;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("busy out of reset");
endmodule // fmt_checker
`default_nettype wire

// File: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic slow,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	logic [7:0] q [$];
	logic [1:0] cnt_q = 2'h0;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// A slow host is ready one cycle in four, so held characters get exercised.
	always @(posedge clk) begin
		cnt_q <= cnt_q + 2'h1;
		tx_ready <= !slow || cnt_q == 2'h3;
		if (tx_valid && tx_ready) begin
			q.push_back(tx_data);
		end
	end
	// The caller sends a trigger last and sends blocks only after the go-ahead.
	task send(input logic [7:0] b);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
	endtask
endmodule // host_model
`default_nettype wire

// File: tb/serial_handshake_output_formatter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_handshake_output_formatter_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic resp_valid = 1'b0;
	logic [7:0] resp_data = 8'h00;
	logic resp_last = 1'b0;
	logic [15:0] buf_level = 16'h0000;
	logic slow = 1'b0;
	logic [15:0] reg_rdata;
	logic rx_valid, rx_accept, resp_ready, tx_valid, tx_ready, dtr;
	logic [7:0] rx_data, rx_out_data, tx_data;
	int n_errors = 0;
	int n_tests = 0;
	always #4 clk = ~clk;
	serial_handshake_output_formatter i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_accept(rx_accept), .rx_out_data(rx_out_data),
		.resp_valid(resp_valid), .resp_data(resp_data), .resp_last(resp_last),
		.resp_ready(resp_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.buf_level(buf_level), .dtr(dtr));
	host_model i_host (.clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd_chk(input string name, input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(name, exp, reg_rdata);
	endtask
	task lvl(input logic [15:0] v);
		@(posedge clk);
		buf_level <= v;
	endtask
	// Source holds the byte until the edge at which the take pulse is seen.
	task resp(input logic [7:0] b, input logic last);
		int i;
		@(posedge clk);
		resp_valid <= 1'b1;
		resp_data <= b;
		resp_last <= last;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (resp_ready !== 1'b1 && i < 3000);
		chk("resp_ready", 16'h0001, {15'h0, resp_ready});
		if (last) resp_valid <= 1'b0;
	endtask
	task req2;
		resp(8'h41, 1'b0);
		resp(8'h42, 1'b1);
	endtask
	task tx_wait(input int n);
		int i;
		i = 0;
		while (i_host.q.size() < n && i < 3000) begin
			@(posedge clk);
			i++;
		end
		repeat (40) @(posedge clk);
	endtask
	task exp_tx(input logic [7:0] e [$]);
		tx_wait(e.size());
		chk("tx count", 16'(e.size()), 16'(i_host.q.size()));
		foreach (e[k]) chk("tx char", {8'h00, e[k]}, {8'h00, i_host.q[k]});
		i_host.q.delete();
	endtask
	task first_tx(input logic [7:0] b);
		tx_wait(1);
		chk("tx first", {8'h00, b}, {8'h00, i_host.q[0]});
		i_host.q.delete();
	endtask
	task no_tx;
		repeat (100) @(posedge clk);
		chk("tx count", 16'h0000, 16'(i_host.q.size()));
	endtask
	task rx_chk(input logic [7:0] b, input logic acc);
		i_host.send(b);
		#1 chk("rx_accept", {15'h0, acc}, {15'h0, rx_accept});
		if (acc) chk("rx_out_data", {8'h00, b}, {8'h00, rx_out_data});
	endtask
	task dtr_chk(input logic v);
		repeat (4) @(posedge clk);
		#1 chk("dtr", {15'h0, v}, {15'h0, dtr});
	endtask
	task t_defaults;
		rd_chk("turn", fmt_pkg::A_TURN, 16'h0000);
		rd_chk("trig", fmt_pkg::A_TRIG, 16'h0000);
		rd_chk("echo", fmt_pkg::A_ECHO, 16'h0000);
		rd_chk("term", fmt_pkg::A_TERM, 16'h000d);
		rd_chk("init", fmt_pkg::A_INIT, 16'h0000);
		rd_chk("icd", fmt_pkg::A_ICD, 16'h0000);
		rd_chk("listlen", fmt_pkg::A_LISTLEN, 16'h0000);
		rd_chk("xoffthr", fmt_pkg::A_XOFFTHR, 16'h0050);
		chk("dtr", 16'h0001, {15'h0, dtr});
	endtask
	task t_format;
		slow <= 1'b1;
		req2;
		exp_tx('{8'h41, 8'h42, 8'h0d});
		slow <= 1'b0;
		wr(fmt_pkg::A_INIT, 16'h0002);
		wr(fmt_pkg::A_TERM, 16'h0a0d);
		req2;
		exp_tx('{8'h02, 8'h41, 8'h42, 8'h0d, 8'h0a});
		wr(fmt_pkg::A_TERM, 16'h0a00);
		req2;
		exp_tx('{8'h02, 8'h41, 8'h42});
		wr(fmt_pkg::A_CMD, 16'h0001);
		rd_chk("term", fmt_pkg::A_TERM, 16'h000d);
		rd_chk("init", fmt_pkg::A_INIT, 16'h0000);
	endtask
	task t_trig_echo;
		wr(fmt_pkg::A_TRIG, 16'h0011);
		fork
			resp(8'h41, 1'b1);
			begin
				no_tx;
				i_host.send(8'h11);
			end
		join
		exp_tx('{8'h41, 8'h0d});
		wr(fmt_pkg::A_TRIG, 16'h0000);
		wr(fmt_pkg::A_ECHO, 16'h000a);
		resp(8'h41, 1'b1);
		exp_tx('{8'h41, 8'h0d});
		rx_chk(8'h42, 1'b0);
		i_host.send(8'h0a);
		rx_chk(8'h43, 1'b1);
		wr(fmt_pkg::A_ECHO, 16'h0000);
	endtask
	task t_enq;
		rx_chk(8'h05, 1'b1);
		wr(fmt_pkg::A_ENQ, 16'h0005);
		wr(fmt_pkg::A_LISTLEN, 16'h0001);
		wr(fmt_pkg::A_LIST, 16'h0013);
		wr(fmt_pkg::A_ACKLEN, 16'h0001);
		wr(fmt_pkg::A_ACK, 16'h0006);
		lvl(16'd945);
		rx_chk(8'h05, 1'b0);
		first_tx(8'h13);
		no_tx;
		lvl(16'd944);
		first_tx(8'h06);
		wr(fmt_pkg::A_ENQ, 16'h0000);
	endtask
	task t_hw;
		wr(fmt_pkg::A_MODE, 16'h0002);
		lvl(16'd945);
		dtr_chk(1'b0);
		lvl(16'd944);
		dtr_chk(1'b0);
		lvl(16'd943);
		dtr_chk(1'b1);
		lvl(16'd1000);
		dtr_chk(1'b0);
		wr(fmt_pkg::A_MODE, 16'h0000);
		dtr_chk(1'b1);
	endtask
	task t_flow;
		lvl(16'd944);
		wr(fmt_pkg::A_MODE, 16'h0001);
		wr(fmt_pkg::A_XONLEN, 16'h0001);
		wr(fmt_pkg::A_XON, 16'h0011);
		no_tx;
		lvl(16'd945);
		first_tx(8'h13);
		lvl(16'd865);
		no_tx;
		lvl(16'd864);
		first_tx(8'h11);
		lvl(16'd0);
		wr(fmt_pkg::A_BUFSIZE, 16'h0200);
		lvl(16'd432);
		no_tx;
		lvl(16'd433);
		first_tx(8'h13);
		lvl(16'd352);
		first_tx(8'h11);
	endtask
	task t_limits;
		wr(fmt_pkg::A_TURN, 16'h2710);
		rd_chk("turn", fmt_pkg::A_TURN, 16'h270f);
		wr(fmt_pkg::A_ICD, 16'hffff);
		rd_chk("icd", fmt_pkg::A_ICD, 16'h270f);
		wr(fmt_pkg::A_XOFFTHR, 16'h0064);
		wr(fmt_pkg::A_CMD, 16'h0007);
		rd_chk("turn", fmt_pkg::A_TURN, 16'h0000);
		rd_chk("icd", fmt_pkg::A_ICD, 16'h0000);
		rd_chk("listlen", fmt_pkg::A_LISTLEN, 16'h0000);
		rd_chk("xoffthr", fmt_pkg::A_XOFFTHR, 16'h0050);
	endtask
	task finish_test;
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_defaults;
		t_format;
		t_trig_echo;
		t_enq;
		t_hw;
		t_flow;
		t_limits;
		finish_test;
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		finish_test;
	end
endmodule // serial_handshake_output_formatter_tb_top
bind serial_handshake_output_formatter fmt_checker i_sva (.clk(clk), .rst_n(rst_n),
	.rx_valid(rx_valid), .rx_data(rx_data), .rx_accept(rx_accept), .rx_out_data(rx_out_data),
	.resp_valid(resp_valid), .resp_data(resp_data), .resp_ready(resp_ready),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .buf_level(buf_level),
	.dtr(dtr));
`default_nettype wire
